// ===== verilog/flash_write_protect_status.v
// Write-protect, status and segment logic of a serial NOR flash behind its serial pins
`timescale 1ns/1ps
`include "flash_wp_map.vh"
module flash_write_protect_status #(
  parameter BUSY_CYCLES = `BUSY_CYCLES_DEFAULT,
  parameter LOCK_BITS = 1054
) (
  input wire sys_clk,
  input wire rst_b,
  input wire sclk,
  input wire cs_b,
  input wire si,
  input wire wp_b,
  input wire op_fail,
  output reg so,
  output reg so_oe,
  output reg op_go,
  output reg [2:0] op_kind,
  output reg [25:0] op_addr
);
  function [2:0] addr_len;
    input [7:0] op;
    input wide4;
    begin
      case (op)
        `CMD_PAGE_PROGRAM, `CMD_SECTOR_ERASE, `CMD_BLOCK_ERASE, `CMD_LOCK, `CMD_UNLOCK, `CMD_READ_LOCK,
        `CMD_SECURITY_PROGRAM, `CMD_SECURITY_ERASE, `CMD_VOLATILE_CFG_WRITE, `CMD_PERSISTENT_CFG_WRITE: begin
          addr_len = wide4 ? 3'd4 : 3'd3;
        end
        default: begin
          addr_len = 3'd0;
        end
      endcase
    end
  endfunction

  // Segment bits replace address bits 25:24 only in 3-byte mode
  function [25:0] phys;
    input [31:0] a;
    input wide4;
    input [1:0] seg;
    begin
      phys = wide4 ? a[25:0] : {seg, a[23:0]};
    end
  endfunction

  // Lock index: 16 sectors of block 0, blocks 1..1022, 16 sectors of block 1023
  function [10:0] lock_index;
    input [25:0] a;
    begin
      if (a[25:16] == 10'h000) begin
        lock_index = {7'h00, a[15:12]};
      end else if (a[25:16] == 10'h3FF) begin
        lock_index = `LOCK_TOP_BASE + {7'h00, a[15:12]};
      end else begin
        lock_index = {1'b0, a[25:16]} + 11'h00F;
      end
    end
  endfunction

  reg [1:0] sclk_s, cs_s, si_s, wp_s;
  reg sclk_d, cs_d;
  reg [2:0] bit_cnt;
  reg [3:0] byte_cnt;
  reg [7:0] shifter, opcode, data0, data1, tx, reply;
  reg [31:0] addr;
  reg [1:0] ndata;
  reg reply_ok;
  reg write_latch_flag, busy, erase_susp, prog_susp, erase_err, prog_err;
  reg sp_low, sp_high, sec_lock, wide, deep_down, reset_armed;
  reg [4:0] region;
  reg [1:0] segment;
  reg [15:0] busy_cnt;
  reg [2:0] cur_kind, start_kind;
  reg [7:0] cfg4_v, cfg5_v, cfg4_p, cfg5_p;
  reg [LOCK_BITS-1:0] locks;
  reg err_prog, err_erase;

  // Edges taken from the second stage only
  wire sclk_rise = sclk_s[1] & ~sclk_d & ~cs_s[1];
  wire sclk_fall = ~sclk_s[1] & sclk_d & ~cs_s[1];
  wire frame_start = ~cs_s[1] & cs_d;
  wire frame_end = cs_s[1] & ~cs_d;
  wire whole = (bit_cnt == 3'd0) && (byte_cnt != 4'h0);
  wire [7:0] rx_next = {shifter[6:0], si_s[1]};
  wire [7:0] op_now = (byte_cnt == 4'h0) ? rx_next : opcode;
  wire [2:0] alen_now = addr_len(op_now, wide);
  wire [31:0] addr_next = {addr[23:0], rx_next};
  wire [25:0] rd_phys = phys((byte_cnt <= {1'b0, alen_now}) ? addr_next : addr, wide, segment);
  wire addr_ok = byte_cnt > {1'b0, addr_len(opcode, wide)};
  wire [25:0] tgt = phys(addr, wide, segment);
  wire [10:0] tgt_idx = lock_index(tgt);
  wire scheme_bp = cfg4_v[`CFG_SCHEME_BIT];
  wire hw_low = ~wp_s[1];
  wire suspended = erase_susp | prog_susp;
  wire busy_flag = busy & ~suspended;
  wire [7:0] status_low = {sp_low, region, write_latch_flag, busy_flag};
  wire [7:0] status_high = {erase_susp, sp_high, erase_err, prog_err, sec_lock, prog_susp, 1'b0, wide};
  wire bp_hit, bp_any;
  wire blk_locked = (tgt[25:16] == 10'h000) ? |locks[15:0] :
                    (tgt[25:16] == 10'h3FF) ? |locks[LOCK_BITS-1:LOCK_BITS-16] : locks[tgt_idx];
  wire sect_prot = scheme_bp ? bp_hit : locks[tgt_idx];
  wire blk_prot = scheme_bp ? bp_hit : blk_locked;
  wire chip_prot = scheme_bp ? bp_any : |locks;
  wire status_open = write_latch_flag & ~sp_high & ~(sp_low & hw_low);
  wire do_soft = frame_end & whole & (opcode == `CMD_RESET) & reset_armed;

  flash_region_decode u_region (
    .region(region),
    .block(tgt[25:16]),
    .hit(bp_hit),
    .any(bp_any)
  );

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      sclk_s <= 2'b00;
      cs_s <= 2'b11;
      si_s <= 2'b00;
      wp_s <= 2'b11;
      sclk_d <= 1'b0;
      cs_d <= 1'b1;
    end else begin
      sclk_s <= {sclk_s[0], sclk};
      cs_s <= {cs_s[0], cs_b};
      si_s <= {si_s[0], si};
      wp_s <= {wp_s[0], wp_b};
      sclk_d <= sclk_s[1];
      cs_d <= cs_s[1];
    end
  end

  // Read answers; a powered-down part drives nothing
  always @* begin
    reply = 8'h00;
    reply_ok = 1'b0;
    if (!deep_down) begin
      case (op_now)
        `CMD_READ_STATUS_LOW: begin
          reply = status_low;
          reply_ok = 1'b1;
        end
        `CMD_READ_STATUS_HIGH: begin
          reply = status_high;
          reply_ok = 1'b1;
        end
        `CMD_SEGMENT_READ: begin
          reply = {6'h00, segment};
          reply_ok = 1'b1;
        end
        `CMD_READ_LOCK: begin
          if (byte_cnt >= {1'b0, alen_now}) begin
            reply = {7'h00, locks[lock_index(rd_phys)]};
            reply_ok = 1'b1;
          end
        end
        default: begin
          reply_ok = 1'b0;
        end
      endcase
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      bit_cnt <= 3'd0;
      byte_cnt <= 4'h0;
      shifter <= 8'h00;
      opcode <= 8'h00;
      addr <= 32'h00000000;
      data0 <= 8'h00;
      data1 <= 8'h00;
      ndata <= 2'd0;
      tx <= 8'h00;
      so <= 1'b0;
      so_oe <= 1'b0;
    end else if (frame_start) begin
      bit_cnt <= 3'd0;
      byte_cnt <= 4'h0;
      ndata <= 2'd0;
      tx <= 8'h00;
      so_oe <= 1'b0;
    end else if (sclk_rise) begin
      shifter <= rx_next;
      bit_cnt <= bit_cnt + 3'd1;
      if (bit_cnt == 3'd7) begin
        if (byte_cnt != 4'hF) begin
          byte_cnt <= byte_cnt + 4'h1;
        end
        if (byte_cnt == 4'h0) begin
          opcode <= rx_next;
        end else if (byte_cnt <= {1'b0, alen_now}) begin
          addr <= addr_next;
        end else if (ndata == 2'd0) begin
          data0 <= rx_next;
          ndata <= 2'd1;
        end else if (ndata == 2'd1) begin
          data1 <= rx_next;
          ndata <= 2'd2;
        end
        tx <= reply;
        if (reply_ok) begin
          so_oe <= 1'b1;
        end
      end
    end else if (sclk_fall) begin
      so <= tx[7];
      tx <= {tx[6:0], 1'b0};
    end else if (cs_s[1]) begin
      so_oe <= 1'b0;
    end
  end

  // Which array or register operation a finished frame launches
  always @* begin
    start_kind = `KIND_NONE;
    err_prog = 1'b0;
    err_erase = 1'b0;
    if (frame_end && whole && !deep_down && !busy && write_latch_flag) begin
      case (opcode)
        `CMD_PAGE_PROGRAM: begin
          if (addr_ok && sect_prot) err_prog = 1'b1;
          else if (addr_ok) start_kind = `KIND_PROGRAM;
        end
        `CMD_SECTOR_ERASE: begin
          if (addr_ok && sect_prot) err_erase = 1'b1;
          else if (addr_ok) start_kind = `KIND_SECTOR;
        end
        `CMD_BLOCK_ERASE: begin
          if (addr_ok && blk_prot) err_erase = 1'b1;
          else if (addr_ok) start_kind = `KIND_BLOCK;
        end
        `CMD_CHIP_ERASE, `CMD_CHIP_ERASE_ALT: begin
          if (chip_prot) err_erase = 1'b1;
          else start_kind = `KIND_CHIP;
        end
        `CMD_SECURITY_PROGRAM: begin
          if (addr_ok && sec_lock) err_prog = 1'b1;
          else if (addr_ok) start_kind = `KIND_SEC_PROGRAM;
        end
        `CMD_SECURITY_ERASE: begin
          if (addr_ok && sec_lock) err_erase = 1'b1;
          else if (addr_ok) start_kind = `KIND_SEC_ERASE;
        end
        `CMD_STATUS_WRITE: begin
          if (status_open && ndata != 2'd0) start_kind = `KIND_REGISTER;
        end
        `CMD_VOLATILE_CFG_WRITE, `CMD_PERSISTENT_CFG_WRITE: begin
          if (addr_ok && ndata != 2'd0) start_kind = `KIND_REGISTER;
        end
        default: begin
          start_kind = `KIND_NONE;
        end
      endcase
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      write_latch_flag <= 1'b0;
      busy <= 1'b0;
      busy_cnt <= 16'h0000;
      cur_kind <= `KIND_NONE;
      erase_susp <= 1'b0;
      prog_susp <= 1'b0;
      erase_err <= 1'b0;
      prog_err <= 1'b0;
      sp_low <= 1'b0;
      sp_high <= 1'b0;
      sec_lock <= 1'b0;
      region <= `REGION_RESET;
      segment <= `SEGMENT_RESET;
      wide <= 1'b0;
      deep_down <= 1'b0;
      reset_armed <= 1'b0;
      cfg4_v <= `CFG_RESET;
      cfg5_v <= `CFG_RESET;
      cfg4_p <= `CFG_RESET;
      cfg5_p <= `CFG_RESET;
      locks <= {LOCK_BITS{1'b0}};
      op_go <= 1'b0;
      op_kind <= `KIND_NONE;
      op_addr <= 26'h0000000;
    end else begin
      op_go <= 1'b0;
      // Timer halts while suspended, so resume picks up the remainder
      if (busy && !suspended) begin
        if (busy_cnt <= 16'h0001) begin
          busy <= 1'b0;
          write_latch_flag <= 1'b0;
          if (op_fail && (cur_kind == `KIND_PROGRAM || cur_kind == `KIND_SEC_PROGRAM)) prog_err <= 1'b1;
          if (op_fail && (cur_kind == `KIND_SECTOR || cur_kind == `KIND_BLOCK || cur_kind == `KIND_CHIP ||
                          cur_kind == `KIND_SEC_ERASE)) erase_err <= 1'b1;
        end else begin
          busy_cnt <= busy_cnt - 16'h0001;
        end
      end
      if (start_kind != `KIND_NONE) begin
        busy <= 1'b1;
        busy_cnt <= BUSY_CYCLES[15:0];
        cur_kind <= start_kind;
        if (start_kind != `KIND_REGISTER) begin
          op_go <= 1'b1;
          op_kind <= start_kind;
          op_addr <= (start_kind == `KIND_CHIP) ? 26'h0000000 : tgt;
        end
      end
      if (err_prog) begin
        prog_err <= 1'b1;
        write_latch_flag <= 1'b0;
      end
      if (err_erase) begin
        erase_err <= 1'b1;
        write_latch_flag <= 1'b0;
      end
      if (frame_end && whole) begin
        reset_armed <= (opcode == `CMD_RESET_ENABLE);
        if (deep_down) begin
          if (opcode == `CMD_RELEASE) deep_down <= 1'b0;
        end else begin
          case (opcode)
            `CMD_WRITE_ENABLE: begin
              if (!busy) write_latch_flag <= 1'b1;
            end
            `CMD_WRITE_DISABLE: begin
              if (!busy) write_latch_flag <= 1'b0;
            end
            `CMD_STATUS_WRITE: begin
              if (start_kind == `KIND_REGISTER) begin
                if (!hw_low) begin
                  sp_low <= data0[`LOW_PROTECT_BIT];
                  region <= data0[`LOW_REGION_MSB:`LOW_REGION_LSB];
                end
                if (ndata == 2'd2) begin
                  sp_high <= data1[`HIGH_PROTECT_BIT];
                  sec_lock <= sec_lock | data1[`HIGH_SEC_LOCK_BIT];
                end
              end
            end
            `CMD_SEGMENT_WRITE: begin
              if (!busy && write_latch_flag && ndata != 2'd0) begin
                segment <= data0[`SEGMENT_MSB:0];
                write_latch_flag <= 1'b0;
              end
            end
            `CMD_VOLATILE_CFG_WRITE: begin
              if (start_kind == `KIND_REGISTER && addr[7:0] == `CFG_PROTECT_ADDR) cfg4_v <= data0;
              if (start_kind == `KIND_REGISTER && addr[7:0] == `CFG_WIDTH_ADDR) begin
                cfg5_v <= data0;
                wide <= (data0 == `CFG_4BYTE_VALUE);
              end
            end
            `CMD_PERSISTENT_CFG_WRITE: begin
              if (start_kind == `KIND_REGISTER && addr[7:0] == `CFG_PROTECT_ADDR) cfg4_p <= data0;
              if (start_kind == `KIND_REGISTER && addr[7:0] == `CFG_WIDTH_ADDR) cfg5_p <= data0;
            end
            `CMD_LOCK: begin
              if (!busy && addr_ok) locks[tgt_idx] <= 1'b1;
            end
            `CMD_UNLOCK: begin
              if (!busy && addr_ok) locks[tgt_idx] <= 1'b0;
            end
            `CMD_LOCK_ALL: begin
              if (!busy) locks <= {LOCK_BITS{1'b1}};
            end
            `CMD_UNLOCK_ALL: begin
              if (!busy) locks <= {LOCK_BITS{1'b0}};
            end
            `CMD_SUSPEND: begin
              if (busy && (cur_kind == `KIND_SECTOR || cur_kind == `KIND_BLOCK)) erase_susp <= 1'b1;
              if (busy && cur_kind == `KIND_PROGRAM) prog_susp <= 1'b1;
            end
            `CMD_RESUME: begin
              erase_susp <= 1'b0;
              prog_susp <= 1'b0;
              // A failure reported by the finishing timer this cycle wins over the clear
              if (!(busy && !suspended && busy_cnt <= 16'h0001 && op_fail)) begin
                erase_err <= 1'b0;
                prog_err <= 1'b0;
              end
            end
            `CMD_POWER_DOWN: begin
              if (!busy) deep_down <= 1'b1;
            end
            `CMD_ENTER_4BYTE: begin
              wide <= 1'b1;
            end
            `CMD_EXIT_4BYTE: begin
              wide <= 1'b0;
            end
            default: begin
              wide <= wide;
            end
          endcase
        end
      end
      // Soft reset reloads volatile state from the persistent copy
      if (do_soft) begin
        write_latch_flag <= 1'b0;
        busy <= 1'b0;
        erase_susp <= 1'b0;
        prog_susp <= 1'b0;
        erase_err <= 1'b0;
        prog_err <= 1'b0;
        deep_down <= 1'b0;
        segment <= `SEGMENT_RESET;
        cfg4_v <= cfg4_p;
        cfg5_v <= cfg5_p;
        wide <= (cfg5_p == `CFG_4BYTE_VALUE);
        locks <= cfg4_p[`CFG_SCHEME_BIT] ? {LOCK_BITS{1'b0}} : {LOCK_BITS{1'b1}};
      end
    end
  end
endmodule

// ===== verilog/flash_wp_map.vh
// Opcodes, bit positions, reset values and timing counts of the flash write-protect block
`ifndef FLASH_WP_MAP_VH
`define FLASH_WP_MAP_VH
`define CMD_WRITE_ENABLE 8'h06
`define CMD_WRITE_DISABLE 8'h04
`define CMD_READ_STATUS_LOW 8'h05
`define CMD_READ_STATUS_HIGH 8'h35
`define CMD_STATUS_WRITE 8'h01
`define CMD_SEGMENT_WRITE 8'hC5
`define CMD_SEGMENT_READ 8'hC8
`define CMD_PAGE_PROGRAM 8'h02
`define CMD_SECTOR_ERASE 8'h20
`define CMD_BLOCK_ERASE 8'hD8
`define CMD_CHIP_ERASE 8'h60
`define CMD_CHIP_ERASE_ALT 8'hC7
`define CMD_LOCK 8'h36
`define CMD_UNLOCK 8'h39
`define CMD_READ_LOCK 8'h3D
`define CMD_LOCK_ALL 8'h7E
`define CMD_UNLOCK_ALL 8'h98
`define CMD_SUSPEND 8'h75
`define CMD_RESUME 8'h7A
`define CMD_RESET_ENABLE 8'h66
`define CMD_RESET 8'h99
`define CMD_POWER_DOWN 8'hB9
`define CMD_RELEASE 8'hAB
`define CMD_ENTER_4BYTE 8'hB7
`define CMD_EXIT_4BYTE 8'hE9
`define CMD_SECURITY_PROGRAM 8'h42
`define CMD_SECURITY_ERASE 8'h44
`define CMD_VOLATILE_CFG_WRITE 8'h81
`define CMD_PERSISTENT_CFG_WRITE 8'hB1
`define HIGH_SUSP_ERASE_BIT 7
`define HIGH_PROTECT_BIT 6
`define HIGH_SEC_LOCK_BIT 3
`define LOW_PROTECT_BIT 7
`define LOW_REGION_MSB 6
`define LOW_REGION_LSB 2
`define SEGMENT_MSB 1
`define CFG_PROTECT_ADDR 8'h04
`define CFG_SCHEME_BIT 2
`define CFG_WIDTH_ADDR 8'h05
`define CFG_4BYTE_VALUE 8'hFE
`define CFG_RESET 8'hFF
`define REGION_RESET 5'h00
`define SEGMENT_RESET 2'h0
`define LOCK_TOP_BASE 11'h40E
`define KIND_NONE 3'h0
`define KIND_PROGRAM 3'h1
`define KIND_SECTOR 3'h2
`define KIND_BLOCK 3'h3
`define KIND_CHIP 3'h4
`define KIND_SEC_PROGRAM 3'h5
`define KIND_SEC_ERASE 3'h6
`define KIND_REGISTER 3'h7
`define BUSY_CYCLES_DEFAULT 16
`endif

// ===== verilog/flash_region_decode.v
// Region-select decode to a protected-block hit
`timescale 1ns/1ps
module flash_region_decode (
  input wire [4:0] region,
  input wire [9:0] block,
  output reg hit,
  output wire any
);
  wire [3:0] n = region[3:0];
  wire [10:0] span = 11'h001 << (n - 4'h1);

  assign any = (n != 4'h0);
  always @* begin
    hit = 1'b0;
    if (n == 4'h0) begin
      hit = 1'b0;
    end else if (n[3:2] == 2'b11 || n == 4'hB) begin
      hit = 1'b1;
    end else if (region[4]) begin
      hit = ({1'b0, block} < span);
    end else begin
      hit = ({1'b0, block} >= (11'h400 - span));
    end
  end
endmodule

// ===== test/flash_wp_checker_assertions.sv
// Port-level assertions for the flash write-protect and status block
`timescale 1ns/1ps
module flash_wp_checker #(
  parameter BUSY_CYCLES = 16
) (
  input wire sys_clk,
  input wire rst_b,
  input wire sclk,
  input wire cs_b,
  input wire si,
  input wire wp_b,
  input wire op_fail,
  input wire so,
  input wire so_oe,
  input wire op_go,
  input wire [2:0] op_kind,
  input wire [25:0] op_addr
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  reg [15:0] gap;
  // Saturates so the first launch after reset always passes
  always @(posedge sys_clk) begin
    if (!rst_b)
      gap <= 16'hFFFF;
    else if (op_go)
      gap <= 16'h0000;
    else if (gap != 16'hFFFF)
      gap <= gap + 16'h0001;
  end
  sequence s_frame_close;
    $rose(cs_b);
  endsequence
  sequence s_drive_off;
    ##[1:6] !so_oe;
  endsequence
  property p_go_single;
    op_go |=> !op_go;
  endproperty
  a_go_single: assert property (p_go_single) else $error("launch pulse too long");
  property p_go_gap;
    op_go |-> gap >= BUSY_CYCLES;
  endproperty
  a_go_gap: assert property (p_go_gap) else $error("launch while busy");
  property p_go_kind;
    op_go |-> (op_kind >= 3'h1) && (op_kind <= 3'h6);
  endproperty
  a_go_kind: assert property (p_go_kind) else $error("bad launch kind");
  property p_go_after_frame;
    op_go |-> $past(cs_b, 1) && $past(cs_b, 3);
  endproperty
  a_go_after_frame: assert property (p_go_after_frame) else $error("launch inside frame");
  property p_chip_addr;
    op_go && (op_kind == 3'h4) |-> op_addr == 26'h0000000;
  endproperty
  a_chip_addr: assert property (p_chip_addr) else $error("chip erase not whole array");
  property p_oe_start;
    $rose(so_oe) |-> !cs_b;
  endproperty
  a_oe_start: assert property (p_oe_start) else $error("drive while deselected");
  property p_oe_end;
    s_frame_close |-> s_drive_off;
  endproperty
  a_oe_end: assert property (p_oe_end) else $error("drive outlives frame");
  property p_so_on_fall;
    so_oe && $past(so_oe) && (so != $past(so)) |-> !sclk;
  endproperty
  a_so_on_fall: assert property (p_so_on_fall) else $error("output moved on high clock");
  property p_quiet_reset;
    $rose(rst_b) |-> (!op_go && !so_oe) [*3];
  endproperty
  a_quiet_reset: assert property (p_quiet_reset) else $error("activity after reset");
endmodule

// ===== test/spi_host_model.sv
// Mode 0 serial host that drives the flash pins
`timescale 1ns/1ps
module spi_host_model (
  input wire sys_clk,
  output reg sclk,
  output reg cs_b,
  output reg si,
  input wire so
);
  integer half = 4;
  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
    si = 1'b1;
  end
  // Samples at end of high phase, long after the device moves so
  task xfer(input [63:0] tx, input integer n, output [63:0] rx);
    integer i;
    begin
      rx = 64'h0;
      @(negedge sys_clk);
      cs_b = 1'b0;
      for (i = 0; i < 8 * n; i = i + 1) begin
        si = tx[63 - i];
        repeat (half) @(negedge sys_clk);
        sclk = 1'b1;
        repeat (half) @(negedge sys_clk);
        rx = {rx[62:0], so};
        sclk = 1'b0;
      end
      repeat (half) @(negedge sys_clk);
      cs_b = 1'b1;
      si = ~si;
    end
  endtask
endmodule

// ===== test/tb.sv
// Self-checking bench for the flash write-protect and status block
`timescale 1ns/1ps
module tb;
  localparam BUSY = 400;
  reg sys_clk = 1'b0;
  reg rst_b = 1'b0;
  reg wp_b = 1'b1;
  reg op_fail = 1'b0;
  reg w4 = 1'b0;
  wire sclk, cs_b, si, so, so_oe, op_go;
  wire [2:0] op_kind;
  wire [25:0] op_addr;
  integer num_errors = 0;
  integer comparisons = 0;
  integer cyc = 0;
  integer gos = 0;
  integer k;
  reg [25:0] go_addr;
  reg [2:0] go_kind;
  reg [63:0] rx;
  reg [73:0] e;
  // Released line shows the inverse so a stale bit never reads as data
  wire so_line = (so_oe === 1'b1) ? so : ~so;
  always #50 sys_clk = ~sys_clk;
  flash_write_protect_status #(.BUSY_CYCLES(BUSY)) flash_write_protect_status_inst (.sys_clk(sys_clk),
    .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .si(si), .wp_b(wp_b), .op_fail(op_fail), .so(so),
    .so_oe(so_oe), .op_go(op_go), .op_kind(op_kind), .op_addr(op_addr));
  spi_host_model spi_host_model_inst (.sys_clk(sys_clk), .sclk(sclk), .cs_b(cs_b), .si(si), .so(so_line));
  task tally_and_finish;
    begin
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (op_go === 1'b1) begin
      gos <= gos + 1;
      go_addr <= op_addr;
      go_kind <= op_kind;
    end
    if (cyc == 80000) begin
      num_errors = num_errors + 1;
      tally_and_finish;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task cmd(input [63:0] tx, input integer n);
    begin
      spi_host_model_inst.xfer(tx, n, rx);
      repeat (8) @(negedge sys_clk);
    end
  endtask
  task wcmd(input [63:0] tx, input integer n);
    begin
      cmd({8'h06, 56'h0}, 1);
      cmd(tx, n);
    end
  endtask
  task rd(input [7:0] opc, input [7:0] exp);
    begin
      cmd({opc, 56'h0}, 2);
      chk(rx[7:0], exp);
    end
  endtask
  task swr(input [7:0] lo, input [7:0] hi);
    begin
      wcmd({8'h01, lo, hi, 40'h0}, 3);
      repeat (BUSY) @(negedge sys_clk);
    end
  endtask
  task lk(input [23:0] a, input b);
    begin
      cmd({8'h3D, a, 32'h0}, 5);
      chk(rx[0], b);
    end
  endtask
  task op(input [7:0] opc, input [2:0] kind, input [31:0] a, input we, input ok);
    integer g;
    integer n;
    reg [63:0] tx;
    begin
      g = gos;
      tx = w4 ? {opc, a, 8'hA5, 16'h0} : {opc, a[23:0], 8'hA5, 24'h0};
      n = (kind == 3'h4) ? 1 : (w4 ? 5 : 4) + (kind == 3'h1);
      if (we)
        cmd({8'h06, 56'h0}, 1);
      cmd(tx, n);
      chk(gos - g, ok);
      if (ok) begin
        chk(go_kind, kind);
        chk(go_addr, a);
        repeat (BUSY) @(negedge sys_clk);
      end
    end
  endtask
  function [73:0] ent(input integer i);
    case (i)
      0: ent = {8'h04, 32'h03FF0000, 1'b0, 32'h03FEFFFF, 1'b1};
      1: ent = {8'h28, 32'h02000000, 1'b0, 32'h01FFFFFF, 1'b1};
      2: ent = {8'h44, 32'h0000FFFF, 1'b0, 32'h00010000, 1'b1};
      3: ent = {8'h68, 32'h01FFFFFF, 1'b0, 32'h02000000, 1'b1};
      4: ent = {8'h2C, 32'h00000000, 1'b0, 32'h03FFFFFF, 1'b0};
      5: ent = {8'h70, 32'h01000000, 1'b0, 32'h02FFFFFF, 1'b0};
      default: ent = {8'h40, 32'h00000000, 1'b1, 32'h03FFFFFF, 1'b1};
    endcase
  endfunction
  initial begin
    repeat (16) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge sys_clk);
    rd(8'h05, 8'h00);
    rd(8'h35, 8'h00);
    rd(8'hC8, 8'h00);
    op(8'h02, 3'h1, 32'h00000100, 1'b0, 1'b0);
    cmd({8'h06, 56'h0}, 1);
    rd(8'h05, 8'h02);
    cmd({8'h04, 56'h0}, 1);
    rd(8'h05, 8'h00);
    for (k = 0; k < 2; k = k + 1) begin
      wcmd({k ? 8'h20 : 8'h02, 24'h000200, 8'hA5, 24'h0}, 5 - k);
      rd(8'h05, 8'h03);
      cmd({8'h75, 56'h0}, 1);
      rd(8'h35, k ? 8'h80 : 8'h04);
      cmd({8'h7A, 56'h0}, 1);
      rd(8'h35, 8'h00);
      repeat (BUSY) @(negedge sys_clk);
      rd(8'h05, 8'h00);
    end
    wcmd({8'hC5, 8'h02, 48'h0}, 2);
    rd(8'h05, 8'h00);
    rd(8'hC8, 8'h02);
    op(8'h20, 3'h2, 32'h02001000, 1'b1, 1'b1);
    wcmd({8'hC5, 8'h00, 48'h0}, 2);
    cmd({8'hB7, 56'h0}, 1);
    w4 = 1'b1;
    rd(8'h35, 8'h01);
    for (k = 0; k < 7; k = k + 1) begin
      e = ent(k);
      swr(e[73:66], 8'h00);
      rd(8'h05, e[73:66]);
      op(8'h02, 3'h1, e[65:34], 1'b1, e[33]);
      if (k == 0)
        rd(8'h35, 8'h11);
      op(8'h02, 3'h1, e[32:1], 1'b1, e[0]);
      op(8'h60, 3'h4, 32'h0, 1'b1, k == 6);
    end
    swr(8'h00, 8'h00);
    cmd({8'hE9, 56'h0}, 1);
    w4 = 1'b0;
    swr(8'h80, 8'h00);
    wp_b = 1'b0;
    swr(8'h04, 8'h00);
    rd(8'h05, 8'h82);
    wp_b = 1'b1;
    swr(8'h04, 8'h00);
    rd(8'h05, 8'h04);
    wp_b = 1'b0;
    swr(8'h80, 8'h40);
    rd(8'h05, 8'h04);
    rd(8'h35, 8'h70);
    wp_b = 1'b1;
    swr(8'h00, 8'h00);
    rd(8'h35, 8'h70);
    rst_b = 1'b0;
    repeat (16) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge sys_clk);
    rd(8'h35, 8'h00);
    cmd({8'hB9, 56'h0}, 1);
    cmd({8'h06, 56'h0}, 1);
    cmd({8'hAB, 56'h0}, 1);
    rd(8'h05, 8'h00);
    cmd({8'h06, 56'h0}, 1);
    cmd({8'h66, 56'h0}, 1);
    cmd({8'h99, 56'h0}, 1);
    rd(8'h05, 8'h00);
    op_fail = 1'b1;
    op(8'h02, 3'h1, 32'h00000300, 1'b1, 1'b1);
    op_fail = 1'b0;
    rd(8'h35, 8'h10);
    cmd({8'h7A, 56'h0}, 1);
    rd(8'h35, 8'h00);
    wcmd({8'hB1, 24'h000004, 8'hFB, 24'h0}, 5);
    repeat (BUSY) @(negedge sys_clk);
    cmd({8'h66, 56'h0}, 1);
    cmd({8'h99, 56'h0}, 1);
    op(8'h02, 3'h1, 32'h00000000, 1'b1, 1'b0);
    lk(24'h010000, 1'b1);
    cmd({8'h98, 56'h0}, 1);
    cmd({8'h36, 24'h001000, 32'h0}, 4);
    op(8'h02, 3'h1, 32'h00001000, 1'b1, 1'b0);
    op(8'h02, 3'h1, 32'h00000000, 1'b1, 1'b1);
    cmd({8'h39, 24'h001000, 32'h0}, 4);
    lk(24'h001000, 1'b0);
    op(8'h02, 3'h1, 32'h00001000, 1'b1, 1'b1);
    cmd({8'h7E, 56'h0}, 1);
    op(8'h02, 3'h1, 32'h00010000, 1'b1, 1'b0);
    op(8'hD8, 3'h3, 32'h00020000, 1'b1, 1'b0);
    op(8'h42, 3'h5, 32'h00000100, 1'b1, 1'b1);
    swr(8'h00, 8'h08);
    op(8'h42, 3'h5, 32'h00000100, 1'b1, 1'b0);
    op(8'h44, 3'h6, 32'h00000100, 1'b1, 1'b0);
    wcmd({8'h81, 24'h000005, 8'hFE, 24'h0}, 5);
    repeat (BUSY) @(negedge sys_clk);
    rd(8'h35, 8'h39);
    tally_and_finish;
  end
endmodule
bind flash_write_protect_status flash_wp_checker #(.BUSY_CYCLES(BUSY_CYCLES)) flash_wp_checker_inst (
  .sys_clk(sys_clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .si(si), .wp_b(wp_b), .op_fail(op_fail),
  .so(so), .so_oe(so_oe), .op_go(op_go), .op_kind(op_kind), .op_addr(op_addr));
